// ---- core/tasm_alarm.sv ----
// Alarm status latch, per-source mask and alert pin driver.
// Assumes a serial interface engine on the same clock issues single-cycle
// register accesses, and measurement logic supplies live temperatures.
//
// Behaviour
// - Alarm bits stay set until a status read, then clear if condition gone.
// - Bit 7 shows conversion busy and never drives the alert pin.
// - Bit 6 sets when local temperature is above its high setpoint.
// - Status bit 5 always reads zero.
// - Bit 4 sets when remote temperature is strictly above remote high setpoint.
// - Bit 3 sets when remote temperature is strictly below remote low setpoint.
// - Bit 2 reports open or shorted remote diode, never drives alert.
// - Bit 1 sets when remote temperature strictly exceeds the critical limit.
// - Bit 0 sets when tachometer count exceeds its limit.
// - Mask bits 7, 5 and 2 always read as one.
// - Mask bit 6 blocks local high alarm from alert when set.
// - Mask bit 4 blocks remote high alarm from alert when set.
// - Mask bit 3 blocks remote low alarm from alert when set.
// - Mask bit 1 blocks critical alarm from alert when set.
// - Mask bit 0 blocks tachometer alarm from alert when set.
// - Mode bit: zero gives latched alert, one follows live conditions.
`include "tasm_params.svh"

module tasm_alarm (
	input  wire logic            ref_clk_i,
	input  wire logic            reset_i,
	input  tasm_pkg::tasm_meas_t meas_i,
	input  tasm_pkg::tasm_req_t  req_i,
	input  wire logic            comp_mode_i,
	output logic [7:0]           rdata_o,
	output logic                 rvalid_o,
	output logic                 alert_n_o,
	output logic                 alert_oe_o
);
	import tasm_pkg::*;

	logic [7:0] cond;
	logic [7:0] status_r;
	logic [7:0] status_nxt;
	logic [7:0] mask_r;
	logic [7:0] mask_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic       rvalid_r;
	logic       rvalid_nxt;
	logic       alert_r;
	logic       alert_nxt;
	logic       alert_n_r;
	logic       alert_n_nxt;
	logic       rd_status;
	logic       rd_mask;
	logic       wr_mask;
	logic [7:0] latched_pend;
	logic [7:0] live_pend;

	tasm_cmp u_cmp (
		.meas_i (meas_i),
		.cond_o (cond)
	);

	assign rd_status = req_i.rd && (req_i.addr == `TASM_STATUS_OFS);
	assign rd_mask   = req_i.rd && (req_i.addr == `TASM_MASK_OFS);
	assign wr_mask   = req_i.wr && (req_i.addr == `TASM_MASK_OFS);

	// Status latch
	always_comb begin
		status_nxt = status_r;
		if (rd_status) begin
			status_nxt = cond & `TASM_LATCH_SRC;
		end else begin
			status_nxt = (status_r | cond) & `TASM_LATCH_SRC;
		end
		status_nxt[`TASM_BIT_BUSY]   = cond[`TASM_BIT_BUSY];
		status_nxt[`TASM_BIT_UNUSED] = 1'b0;
	end

	// Writes to the status offset fall through: no path updates status
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			status_r <= `TASM_STATUS_RST;
		end else begin
			status_r <= status_nxt;
		end
	end

	// Mask register
	always_comb begin
		mask_nxt = mask_r;
		if (wr_mask) begin
			mask_nxt = req_i.wdata | `TASM_MASK_FIXED;
		end
	end

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			mask_r <= `TASM_MASK_RST;
		end else begin
			mask_r <= mask_nxt;
		end
	end

	// Read port
	always_comb begin
		rdata_nxt  = rdata_r;
		rvalid_nxt = req_i.rd;
		if (rd_status) begin
			rdata_nxt = status_r;
		end else if (rd_mask) begin
			rdata_nxt = mask_r;
		end else if (req_i.rd) begin
			rdata_nxt = 8'h00;
		end
	end

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			rdata_r  <= 8'h00;
			rvalid_r <= 1'b0;
		end else begin
			rdata_r  <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	// Alert generation; busy and fault bits are outside the source set
	assign latched_pend = status_r & `TASM_ALERT_SRC & ~mask_r;
	assign live_pend    = cond & `TASM_ALERT_SRC & ~mask_r;

	always_comb begin
		if (comp_mode_i) begin
			alert_nxt = |live_pend;
		end else begin
			alert_nxt = |latched_pend;
		end
		alert_n_nxt = ~alert_nxt;
	end

	// Pin level and enable in separate flops so both leave a register
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			alert_r   <= 1'b0;
			alert_n_r <= 1'b1;
		end else begin
			alert_r   <= alert_nxt;
			alert_n_r <= alert_n_nxt;
		end
	end

	assign rdata_o    = rdata_r;
	assign rvalid_o   = rvalid_r;
	assign alert_n_o  = alert_n_r;
	assign alert_oe_o = alert_r;

	// Checks

	status_hold_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(!rd_status && (status_r & `TASM_LATCH_SRC) != 8'h00)
		|=> ((status_r & $past(status_r) & `TASM_LATCH_SRC) == ($past(status_r) & `TASM_LATCH_SRC)))
		else $error("latched alarm bit dropped without a status read");

	read_clear_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		rd_status |=> ((status_r & `TASM_LATCH_SRC) == ($past(cond) & `TASM_LATCH_SRC)))
		else $error("status read did not reduce alarms to live conditions");

	read_value_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		rd_status |=> (rvalid_o && rdata_o == $past(status_r)))
		else $error("status read returned wrong value");

	busy_track_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		##1 (status_r[`TASM_BIT_BUSY] == $past(meas_i.conv_busy)))
		else $error("busy bit does not follow conversion");

	bit5_zero_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(rvalid_o && $past(rd_status)) |-> !rdata_o[`TASM_BIT_UNUSED])
		else $error("unused status bit read as one");

	local_high_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(meas_i.local_temp > meas_i.local_high) |=> status_r[`TASM_BIT_LHIGH])
		else $error("local high alarm not latched");

	local_eq_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(rd_status && meas_i.local_temp <= meas_i.local_high) |=> !status_r[`TASM_BIT_LHIGH])
		else $error("local high alarm set at or below setpoint");

	remote_high_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(rd_status && meas_i.remote_temp == meas_i.remote_high) |=> !status_r[`TASM_BIT_RHIGH])
		else $error("remote high alarm set on equality");

	remote_low_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(meas_i.remote_temp < meas_i.remote_low) |=> status_r[`TASM_BIT_RLOW])
		else $error("remote low alarm not latched");

	crit_limit_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(meas_i.remote_temp > $signed({meas_i.crit_limit, 3'b000})) |=> status_r[`TASM_BIT_CRIT])
		else $error("critical alarm not latched");

	tach_slow_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(rd_status && meas_i.tach_count <= meas_i.tach_limit) |=> !status_r[`TASM_BIT_TACH])
		else $error("tachometer alarm set at or below limit");

	fault_quiet_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(!comp_mode_i && (status_r & ~8'h84) == 8'h00) |=> alert_n_o)
		else $error("fault or busy bit drove the alert pin");

	mask_ones_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(mask_r & `TASM_MASK_FIXED) == `TASM_MASK_FIXED)
		else $error("fixed mask bits not one");

	mask_gate_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(!comp_mode_i && ((status_r & `TASM_ALERT_SRC) & ~mask_r) == 8'h00) |=> !alert_oe_o)
		else $error("masked alarm reached the alert pin");

	alert_latch_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(!comp_mode_i && ((status_r & `TASM_ALERT_SRC) & ~mask_r) != 8'h00) |=> (!alert_n_o && alert_oe_o))
		else $error("unmasked latched alarm did not assert alert");

	alert_comp_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		comp_mode_i |=> (alert_n_o == (($past(cond) & `TASM_ALERT_SRC & ~$past(mask_r)) == 8'h00)))
		else $error("comparator mode alert not following live condition");

	status_wr_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(req_i.wr && req_i.addr == `TASM_STATUS_OFS && !rd_status && (cond & 8'h7f) == 8'h00)
		|=> ((status_r & 8'h7f) == ($past(status_r) & 8'h7f)))
		else $error("status register changed on write");

	// Comparator, diode fault latch and unused bit checks
	remote_high_set_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(meas_i.remote_temp > meas_i.remote_high) |=> status_r[`TASM_BIT_RHIGH])
		else $error("remote high alarm not latched");

	remote_low_eq_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(rd_status && meas_i.remote_temp == meas_i.remote_low) |=> !status_r[`TASM_BIT_RLOW])
		else $error("remote low alarm set on equality");

	crit_eq_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(rd_status && meas_i.remote_temp <= $signed({meas_i.crit_limit, 3'b000})) |=> !status_r[`TASM_BIT_CRIT])
		else $error("critical alarm set at or below limit");

	tach_set_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(meas_i.tach_count > meas_i.tach_limit) |=> status_r[`TASM_BIT_TACH])
		else $error("tachometer alarm not latched");

	fault_latch_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		meas_i.diode_fault |=> status_r[`TASM_BIT_FAULT])
		else $error("diode fault not latched");

	bit5_clear_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		!status_r[`TASM_BIT_UNUSED])
		else $error("unused status bit set");

	// Register port checks
	mask_write_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		wr_mask |=> (mask_r == ($past(req_i.wdata) | `TASM_MASK_FIXED)))
		else $error("mask write not stored with fixed ones");

	mask_keep_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		!wr_mask |=> (mask_r == $past(mask_r)))
		else $error("mask changed without a write");

	mask_read_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		rd_mask |=> (rvalid_o && rdata_o == $past(mask_r)))
		else $error("mask read returned wrong value");

	unmapped_zero_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(req_i.rd && !rd_status && !rd_mask) |=> (rvalid_o && rdata_o == 8'h00))
		else $error("unmapped read returned nonzero data");

	// Alert checks
	oe_pair_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		alert_oe_o == !alert_n_o)
		else $error("alert enable and pin level disagree");

	busy_no_alert_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(!comp_mode_i && status_r == 8'h80) |=> !alert_oe_o)
		else $error("busy bit drove the alert enable");

	comp_gate_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(comp_mode_i && (cond & `TASM_ALERT_SRC & ~mask_r) == 8'h00) |=> alert_n_o)
		else $error("masked or non-alert condition drove alert in comparator mode");

	local_unmask_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(!comp_mode_i && status_r[`TASM_BIT_LHIGH] && !mask_r[`TASM_BIT_LHIGH]) |=> !alert_n_o)
		else $error("unmasked local high alarm did not assert alert");

	rhigh_unmask_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(!comp_mode_i && status_r[`TASM_BIT_RHIGH] && !mask_r[`TASM_BIT_RHIGH]) |=> !alert_n_o)
		else $error("unmasked remote high alarm did not assert alert");

	rlow_unmask_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(!comp_mode_i && status_r[`TASM_BIT_RLOW] && !mask_r[`TASM_BIT_RLOW]) |=> !alert_n_o)
		else $error("unmasked remote low alarm did not assert alert");

	crit_unmask_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(!comp_mode_i && status_r[`TASM_BIT_CRIT] && !mask_r[`TASM_BIT_CRIT]) |=> !alert_n_o)
		else $error("unmasked critical alarm did not assert alert");

	tach_unmask_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(!comp_mode_i && status_r[`TASM_BIT_TACH] && !mask_r[`TASM_BIT_TACH]) |=> !alert_n_o)
		else $error("unmasked tachometer alarm did not assert alert");

endmodule

// ---- core/tasm_params.svh ----
// Constants for the thermal alarm status and mask block.
// Assumes 8-bit register offsets on the serial register port.
`ifndef TASM_PARAMS_SVH
`define TASM_PARAMS_SVH

// Register offsets
`define TASM_STATUS_OFS   8'h02
`define TASM_MASK_OFS     8'h16

// Status and mask bit positions
`define TASM_BIT_BUSY     7
`define TASM_BIT_LHIGH    6
`define TASM_BIT_UNUSED   5
`define TASM_BIT_RHIGH    4
`define TASM_BIT_RLOW     3
`define TASM_BIT_FAULT    2
`define TASM_BIT_CRIT     1
`define TASM_BIT_TACH     0

// Reset values
`define TASM_STATUS_RST   8'h00
`define TASM_MASK_RST     8'ha4

// Mask bits that always read as one
`define TASM_MASK_FIXED   8'ha4

// Bits that may drive the alert pin
`define TASM_ALERT_SRC    8'h5b

// Bits that latch until the status register is read
`define TASM_LATCH_SRC    8'h5f

// Fractional bits below the integer degree in remote readings
`define TASM_FRAC_BITS    3

`endif

// ---- core/tasm_pkg.sv ----
// Types shared by the thermal alarm status and mask block.
// Assumes the measurement logic runs on the same clock.
package tasm_pkg;

	// Live measurement and limit values presented by the converter side
	typedef struct packed {
		logic signed [7:0]  local_temp;
		logic signed [7:0]  local_high;
		logic signed [10:0] remote_temp;
		logic signed [10:0] remote_high;
		logic signed [10:0] remote_low;
		logic signed [7:0]  crit_limit;
		logic [15:0]        tach_count;
		logic [15:0]        tach_limit;
		logic               diode_fault;
		logic               conv_busy;
	} tasm_meas_t;

	// One register access from the serial interface engine
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tasm_req_t;

endpackage

// ---- core/tasm_cmp.sv ----
// Alarm condition comparators for the thermal alarm block.
// Assumes all inputs are stable values on the block's own clock.
`include "tasm_params.svh"

module tasm_cmp (
	input  tasm_pkg::tasm_meas_t meas_i,
	output logic [7:0]           cond_o
);
	import tasm_pkg::*;

	logic signed [10:0] crit_ext;

	// Integer limit aligned to the remote reading's fraction bits
	assign crit_ext = $signed({meas_i.crit_limit, {`TASM_FRAC_BITS{1'b0}}});

	always_comb begin
		cond_o = 8'h00;
		cond_o[`TASM_BIT_BUSY]  = meas_i.conv_busy;
		cond_o[`TASM_BIT_LHIGH] = meas_i.local_temp > meas_i.local_high;
		cond_o[`TASM_BIT_RHIGH] = meas_i.remote_temp > meas_i.remote_high;
		cond_o[`TASM_BIT_RLOW]  = meas_i.remote_temp < meas_i.remote_low;
		cond_o[`TASM_BIT_FAULT] = meas_i.diode_fault;
		cond_o[`TASM_BIT_CRIT]  = meas_i.remote_temp > crit_ext;
		cond_o[`TASM_BIT_TACH]  = meas_i.tach_count > meas_i.tach_limit;
	end

endmodule

// ---- verification/tasm_host_model.sv ----
// Host model: issues single-cycle register accesses and captures read answers.
// Assumes the block answers a read with rvalid_o exactly one cycle after the request edge.
module tasm_host_model import tasm_pkg::*; (
	input  wire logic       ref_clk_i,
	input  wire logic       rvalid_i,
	input  wire logic [7:0] rdata_i,
	output tasm_req_t       req_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial req_o = '0;

	// Reads status to find and clear sources, writes mask to silence them
	task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wd,
		output logic [7:0] rd_data);
		@(negedge ref_clk_i);
		req_o = '{rd: !wr, wr: wr, addr: addr, wdata: wd};
		@(negedge ref_clk_i);
		// Missing answer shows as unknown data
		rd_data = rvalid_i ? rdata_i : 8'hxx;
		req_o = '0;
	endtask
endmodule

// ---- verification/tb_thermal_alarm_status_mask.sv ----
// Bench for the alarm status and mask block: registers, latching, masking, alert modes.
// Assumes tasm_host_model for register access and a 250 MHz clock.
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin n_fail++; \
	$display("[ERR] %s exp %h got %h", nm, ex, gt); end end

module tb_thermal_alarm_status_mask import tasm_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic       ref_clk = 1'b0;
	logic       reset = 1'b1;
	logic       comp_mode = 1'b0;
	logic       alert_n;
	logic       alert_oe;
	logic       rvalid;
	logic [7:0] rdata;
	tasm_req_t  req;
	tasm_meas_t meas;
	tasm_meas_t base;
	int         n_fail = 0;
	int         samples_checked = 0;
	int         cycles = 0;
	int         bits[5] = '{6, 4, 3, 1, 0};

	tasm_alarm uut (.ref_clk_i(ref_clk), .reset_i(reset), .meas_i(meas), .req_i(req), .comp_mode_i(comp_mode),
		.rdata_o(rdata), .rvalid_o(rvalid), .alert_n_o(alert_n), .alert_oe_o(alert_oe));
	tasm_host_model host (.ref_clk_i(ref_clk), .rvalid_i(rvalid), .rdata_i(rdata), .req_o(req));

	initial forever #2 ref_clk = ~ref_clk;

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		host.access(1'b0, a, 8'h00, d);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] w);
		logic [7:0] d;
		host.access(1'b1, a, w, d);
	endtask

	// Limit at equality when hit is low, one step past it when high
	task automatic set_lim(input int b, input logic hit);
		meas = base;
		case (b)
			6: meas.local_high = hit ? 8'h09 : 8'h0a;
			4: meas.remote_high = hit ? 11'h04f : 11'h050;
			3: meas.remote_low = hit ? 11'h051 : 11'h050;
			1: meas.crit_limit = hit ? 8'h09 : 8'h0a;
			default: meas.tach_limit = hit ? 16'h0063 : 16'h0064;
		endcase
	endtask

	task automatic t_regs();
		logic [7:0] d;
		rd(8'h02, d);
		`CHK("status reset", 8'h00, d)
		rd(8'h16, d);
		`CHK("mask reset", 8'ha4, d)
		`CHK("alert idle", 1'b1, alert_n)
		wr(8'h02, 8'hff);
		rd(8'h02, d);
		`CHK("status write", 8'h00, d)
		wr(8'h16, 8'h00);
		rd(8'h16, d);
		`CHK("mask fixed", 8'ha4, d)
		wr(8'h16, 8'hff);
		rd(8'h16, d);
		`CHK("mask all", 8'hff, d)
		rd(8'h03, d);
		`CHK("unmapped", 8'h00, d)
		wr(8'h16, 8'h00);
	endtask

	task automatic t_latch(input int b);
		logic [7:0] d;
		set_lim(b, 1'b0);
		tick(3);
		rd(8'h02, d);
		`CHK("equal limit", 8'h00, d & 8'h5b)
		set_lim(b, 1'b1);
		tick(3);
		`CHK("alert on", 1'b0, alert_n)
		`CHK("alert drive", 1'b1, alert_oe)
		meas = base;
		tick(3);
		`CHK("alert held", 1'b0, alert_n)
		rd(8'h02, d);
		`CHK("latched bit", 8'h01 << b, d & 8'h5b)
		tick(2);
		`CHK("alert off", 1'b1, alert_n)
		rd(8'h02, d);
		`CHK("cleared", 8'h00, d & 8'h5b)
		wr(8'h16, 8'h01 << b);
		set_lim(b, 1'b1);
		tick(3);
		`CHK("masked", 1'b1, alert_n)
		meas = base;
		tick(2);
		rd(8'h02, d);
		rd(8'h02, d);
		wr(8'h16, 8'h00);
	endtask

	task automatic t_fault_busy();
		logic [7:0] d;
		meas.diode_fault = 1'b1;
		meas.conv_busy = 1'b1;
		tick(3);
		`CHK("no alert", 1'b1, alert_n)
		rd(8'h02, d);
		`CHK("fault busy", 8'h84, d)
		meas = base;
		tick(2);
		rd(8'h02, d);
		`CHK("fault held", 8'h04, d)
		rd(8'h02, d);
		`CHK("fault gone", 8'h00, d)
	endtask

	task automatic t_comp_mode();
		logic [7:0] d;
		comp_mode = 1'b1;
		set_lim(6, 1'b1);
		tick(2);
		`CHK("live on", 1'b0, alert_n)
		meas = base;
		tick(2);
		`CHK("live off", 1'b1, alert_n)
		comp_mode = 1'b0;
		rd(8'h02, d);
	endtask

	initial begin
		base = '{8'h0a, 8'h14, 11'h050, 11'h0a0, 11'h000, 8'h1e, 16'h0064, 16'h00c8, 1'b0, 1'b0};
		meas = base;
		tick(20);
		reset = 1'b0;
		t_regs();
		foreach (bits[i]) t_latch(bits[i]);
		t_fault_busy();
		t_comp_mode();
		give_verdict();
	end
endmodule
